// ==== hdl/adc_ref_pkg.sv ====
// Purpose: Shared constants for the converter reference select and result coding block
// Assumes: 125 MHz system clock, AXI4-Lite register access with 32-bit data
// Notes: Register offsets are byte addresses of aligned words
package adc_ref_pkg;
  localparam int unsigned CLK_MHZ = 125;
  localparam int unsigned REF_WAKE_US = 10000;
  localparam int unsigned REF_WAKE_CYCLES = REF_WAKE_US * CLK_MHZ;
  localparam int unsigned RESULT_BITS = 12;
  localparam int unsigned NUM_CHANNELS = 12;
  localparam int unsigned ADDR_BITS = 4;

  localparam logic [ADDR_BITS-1:0] SETUP_OFFS = 4'h0;
  localparam logic [ADDR_BITS-1:0] CONV_OFFS = 4'h4;
  localparam logic [ADDR_BITS-1:0] STATUS_OFFS = 4'h8;
  localparam logic [ADDR_BITS-1:0] RESULT_OFFS = 4'hC;

  // Setup register fields
  localparam int unsigned REF_KEEP_ON_POS = 0;
  localparam int unsigned SHARED_PIN_ROLE_POS = 1;
  localparam int unsigned REF_SOURCE_INTERNAL_POS = 2;
  localparam int unsigned BIPOLAR_POS = 3;
  localparam int unsigned DIFFERENTIAL_POS = 4;
  localparam int unsigned SHUTDOWN_POS = 5;
  localparam int unsigned SETUP_BITS = 6;
  localparam logic [SETUP_BITS-1:0] SETUP_RESET = 6'h00;

  // Conversion register fields
  localparam int unsigned CHAN_LSB = 0;
  localparam int unsigned CHAN_BITS = 4;
  localparam int unsigned SCAN_POS = 4;
  localparam int unsigned START_POS = 8;
  localparam logic [CHAN_BITS-1:0] CHAN_RESET = 4'h0;

  // Status register fields
  localparam int unsigned ST_BUSY_POS = 0;
  localparam int unsigned ST_REF_POWER_POS = 1;
  localparam int unsigned ST_REF_READY_POS = 2;
  localparam int unsigned ST_PIN_REF_POS = 3;
  localparam int unsigned ST_PIN_DRIVE_POS = 4;
  localparam int unsigned ST_DONE_POS = 5;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [1:0] REF_OUT_CODE = 2'h3;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_WAKE = 2'b01,
    ST_CONV = 2'b10
  } conv_state_t;
endpackage : adc_ref_pkg

// ==== hdl/adc_ref_ctrl.sv ====
// Purpose: Reference select, shared pin role, conversion issue and result coding
// Assumes: Converter core and power manager run on sys_clk_i; software uses AXI4-Lite
// Notes: The shared pin is the highest channel of the variant; internal reference wake time is a parameter
`timescale 1ns/10ps

module adc_ref_ctrl #(
  parameter int unsigned WAKE_CYCLES = adc_ref_pkg::REF_WAKE_CYCLES,
  parameter int unsigned NUM_CH = adc_ref_pkg::NUM_CHANNELS
) (
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [adc_ref_pkg::ADDR_BITS-1:0] s_axi_awaddr_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  output logic [1:0] s_axi_bresp_o,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  input wire logic [adc_ref_pkg::ADDR_BITS-1:0] s_axi_araddr_i,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  input wire logic sample_valid_i,
  input wire logic [adc_ref_pkg::RESULT_BITS-1:0] sample_raw_i,
  output logic conv_start_o,
  output logic [adc_ref_pkg::CHAN_BITS-1:0] conv_last_chan_o,
  output logic conv_diff_o,
  output logic conv_neg_ground_o,
  output logic ref_power_o,
  output logic ref_internal_o,
  output logic shared_pin_is_ref_o,
  output logic shared_pin_ref_out_o,
  output logic shared_pin_ref_oe_n_o
);
  import adc_ref_pkg::*;

  localparam int unsigned CNT_W = $clog2(WAKE_CYCLES + 1);
  localparam logic [CNT_W-1:0] WAKE_DONE = CNT_W'(WAKE_CYCLES);
  localparam logic [CHAN_BITS-1:0] SHARED_CH = CHAN_BITS'(NUM_CH - 1);
  localparam logic [CHAN_BITS-1:0] SCAN_LIMIT = CHAN_BITS'(NUM_CH - 2);
  localparam logic [CHAN_BITS-2:0] SHARED_PAIR = SHARED_CH[CHAN_BITS-1:1];

  // Bus state
  logic aw_held, next_aw_held, w_held, next_w_held;
  logic [ADDR_BITS-1:0] aw_addr, next_aw_addr;
  logic [31:0] w_data, next_w_data;
  logic [3:0] w_strb, next_w_strb;
  logic next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
  logic [1:0] next_bresp, next_rresp;
  logic [31:0] next_rdata;
  logic wr_fire;

  // Control state
  logic [SETUP_BITS-1:0] setup, next_setup;
  logic [CHAN_BITS-1:0] chan, next_chan;
  logic scan, next_scan;
  logic pending, next_pending;
  logic done, next_done;
  logic ref_power, next_ref_power;
  logic [CNT_W-1:0] wake_cnt, next_wake_cnt;
  logic [RESULT_BITS-1:0] result, next_result;
  conv_state_t state, next_state;
  logic next_conv_start, next_conv_diff, next_neg_ground, next_oe_n;
  logic [CHAN_BITS-1:0] next_last_chan;

  logic internal_sel, pin_is_ref, ref_out_sel, keep_on, shutdown, ref_ready, setup_wr, conv_wr, go;
  logic [SETUP_BITS-1:0] setup_wdata;
  logic [15:0] wmask;
  logic [CHAN_BITS-1:0] top_chan;

  assign internal_sel = setup[REF_SOURCE_INTERNAL_POS];
  assign pin_is_ref = setup[SHARED_PIN_ROLE_POS];
  assign ref_out_sel = (setup[REF_SOURCE_INTERNAL_POS:SHARED_PIN_ROLE_POS] == REF_OUT_CODE);
  assign keep_on = setup[REF_KEEP_ON_POS];
  assign shutdown = setup[SHUTDOWN_POS];
  assign ref_ready = (wake_cnt == WAKE_DONE);
  assign wr_fire = aw_held && w_held && !s_axi_bvalid_o;
  assign wmask = {{8{w_strb[1]}}, {8{w_strb[0]}}};
  assign setup_wr = wr_fire && (aw_addr == SETUP_OFFS) && w_strb[0];
  assign conv_wr = wr_fire && (aw_addr == CONV_OFFS);
  assign setup_wdata = w_data[SETUP_BITS-1:0];
  // External and supply references need no wake-up
  assign go = !shutdown && (!internal_sel || ref_ready);

  // Highest channel: the limiter drops the shared pin from single-ended scans while the pin has the reference role
  always_comb begin
    top_chan = (chan > SHARED_CH) ? SHARED_CH : chan;
    if (scan && pin_is_ref && !setup[DIFFERENTIAL_POS] && top_chan > SCAN_LIMIT) begin
      top_chan = SCAN_LIMIT;
    end
  end

  always_comb begin
    next_aw_held = aw_held;
    next_aw_addr = aw_addr;
    next_w_held = w_held;
    next_w_data = w_data;
    next_w_strb = w_strb;
    next_bvalid = s_axi_bvalid_o;
    next_bresp = s_axi_bresp_o;
    next_arready = s_axi_arready_o;
    next_rvalid = s_axi_rvalid_o;
    next_rdata = s_axi_rdata_o;
    next_rresp = s_axi_rresp_o;
    if (s_axi_awvalid_i && s_axi_awready_o) begin
      next_aw_held = 1'b1;
      next_aw_addr = s_axi_awaddr_i;
    end
    if (s_axi_wvalid_i && s_axi_wready_o) begin
      next_w_held = 1'b1;
      next_w_data = s_axi_wdata_i;
      next_w_strb = s_axi_wstrb_i;
    end
    if (wr_fire) begin
      next_aw_held = 1'b0;
      next_w_held = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = (aw_addr == SETUP_OFFS || aw_addr == CONV_OFFS) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bvalid_o && s_axi_bready_i) begin
      next_bvalid = 1'b0;
    end
    next_awready = !next_aw_held && !next_bvalid;
    next_wready = !next_w_held && !next_bvalid;
    if (s_axi_arvalid_i && s_axi_arready_o) begin
      next_arready = 1'b0;
      next_rvalid = 1'b1;
      next_rresp = RESP_OKAY;
      next_rdata = '0;
      case (s_axi_araddr_i)
        SETUP_OFFS: next_rdata[SETUP_BITS-1:0] = setup;
        CONV_OFFS: begin
          next_rdata[CHAN_LSB +: CHAN_BITS] = chan;
          next_rdata[SCAN_POS] = scan;
        end
        STATUS_OFFS: begin
          next_rdata[ST_BUSY_POS] = pending || (state != ST_IDLE);
          next_rdata[ST_REF_POWER_POS] = ref_power;
          next_rdata[ST_REF_READY_POS] = ref_ready;
          next_rdata[ST_PIN_REF_POS] = pin_is_ref;
          next_rdata[ST_PIN_DRIVE_POS] = !shared_pin_ref_oe_n_o;
          next_rdata[ST_DONE_POS] = done;
        end
        RESULT_OFFS: next_rdata[RESULT_BITS-1:0] = result;
        default: next_rresp = RESP_SLVERR;
      endcase
    end else if (s_axi_rvalid_o && s_axi_rready_i) begin
      next_rvalid = 1'b0;
      next_arready = 1'b1;
    end
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      aw_held <= 1'b0;
      aw_addr <= '0;
      w_held <= 1'b0;
      w_data <= '0;
      w_strb <= '0;
      s_axi_awready_o <= 1'b1;
      s_axi_wready_o <= 1'b1;
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o <= RESP_OKAY;
      s_axi_arready_o <= 1'b1;
      s_axi_rvalid_o <= 1'b0;
      s_axi_rdata_o <= '0;
      s_axi_rresp_o <= RESP_OKAY;
    end else begin
      aw_held <= next_aw_held;
      aw_addr <= next_aw_addr;
      w_held <= next_w_held;
      w_data <= next_w_data;
      w_strb <= next_w_strb;
      s_axi_awready_o <= next_awready;
      s_axi_wready_o <= next_wready;
      s_axi_bvalid_o <= next_bvalid;
      s_axi_bresp_o <= next_bresp;
      s_axi_arready_o <= next_arready;
      s_axi_rvalid_o <= next_rvalid;
      s_axi_rdata_o <= next_rdata;
      s_axi_rresp_o <= next_rresp;
    end
  end

  always_comb begin
    next_setup = setup_wr ? setup_wdata : setup;
    next_chan = chan;
    next_scan = scan;
    next_pending = pending;
    next_done = done;
    next_result = result;
    next_state = state;
    next_conv_start = 1'b0;
    next_last_chan = conv_last_chan_o;
    next_conv_diff = conv_diff_o;
    next_neg_ground = conv_neg_ground_o;
    next_ref_power = ref_power;
    // Only a changed selection releases the reference; rewriting the same code keeps it warm
    if (setup_wr && setup_wdata[REF_SOURCE_INTERNAL_POS:0] != setup[REF_SOURCE_INTERNAL_POS:0]) begin
      next_ref_power = setup_wdata[REF_SOURCE_INTERNAL_POS] && setup_wdata[REF_KEEP_ON_POS];
    end else if (internal_sel && (keep_on || pending)) begin
      next_ref_power = 1'b1;
    end
    next_wake_cnt = wake_cnt;
    if (!next_ref_power) begin
      next_wake_cnt = '0;
    end else if (!ref_ready) begin
      next_wake_cnt = wake_cnt + CNT_W'(1);
    end
    if (conv_wr) begin
      next_chan = (chan & ~wmask[CHAN_LSB +: CHAN_BITS]) | (w_data[CHAN_LSB +: CHAN_BITS] & wmask[CHAN_LSB +: CHAN_BITS]);
      if (w_strb[0]) begin
        next_scan = w_data[SCAN_POS];
      end
    end
    case (state)
      ST_IDLE: begin
        if (pending) begin
          next_state = go ? ST_CONV : ST_WAKE;
          next_conv_start = go;
          next_pending = 1'b0;
          next_done = 1'b0;
          next_last_chan = top_chan;
          next_conv_diff = setup[DIFFERENTIAL_POS];
          next_neg_ground = next_conv_diff && pin_is_ref && (top_chan[CHAN_BITS-1:1] == SHARED_PAIR);
        end
      end
      ST_WAKE: begin
        if (go) begin
          next_state = ST_CONV;
          next_conv_start = 1'b1;
        end
      end
      ST_CONV: begin
        if (sample_valid_i) begin
          next_state = ST_IDLE;
          next_done = 1'b1;
          next_result = sample_raw_i ^ {setup[BIPOLAR_POS], {(RESULT_BITS-1){1'b0}}};
        end
      end
      default: next_state = ST_IDLE;
    endcase
    // A new start request wins over the clear taken at issue
    if (conv_wr && w_strb[1] && w_data[START_POS]) begin
      next_pending = 1'b1;
    end
    next_oe_n = !(next_setup[REF_SOURCE_INTERNAL_POS:SHARED_PIN_ROLE_POS] == REF_OUT_CODE)
      || next_setup[SHUTDOWN_POS] || !next_ref_power;
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      setup <= SETUP_RESET;
      chan <= CHAN_RESET;
      scan <= 1'b0;
      pending <= 1'b0;
      done <= 1'b0;
      result <= '0;
      state <= ST_IDLE;
      ref_power <= 1'b0;
      wake_cnt <= '0;
      conv_start_o <= 1'b0;
      conv_last_chan_o <= CHAN_RESET;
      conv_diff_o <= 1'b0;
      conv_neg_ground_o <= 1'b0;
      ref_power_o <= 1'b0;
      ref_internal_o <= 1'b0;
      shared_pin_is_ref_o <= 1'b0;
      shared_pin_ref_out_o <= 1'b0;
      shared_pin_ref_oe_n_o <= 1'b1;
    end else begin
      setup <= next_setup;
      chan <= next_chan;
      scan <= next_scan;
      pending <= next_pending;
      done <= next_done;
      result <= next_result;
      state <= next_state;
      ref_power <= next_ref_power;
      wake_cnt <= next_wake_cnt;
      conv_start_o <= next_conv_start;
      conv_last_chan_o <= next_last_chan;
      conv_diff_o <= next_conv_diff;
      conv_neg_ground_o <= next_neg_ground;
      ref_power_o <= next_ref_power;
      ref_internal_o <= next_setup[REF_SOURCE_INTERNAL_POS];
      shared_pin_is_ref_o <= next_setup[SHARED_PIN_ROLE_POS];
      shared_pin_ref_out_o <= !next_oe_n;
      shared_pin_ref_oe_n_o <= next_oe_n;
    end
  end

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!nrst_i);

  sequence s_issue_ready;
    state == ST_IDLE && pending && go;
  endsequence
  sequence s_sample_taken;
    state == ST_CONV && sample_valid_i;
  endsequence

  pin_role_a: assert property (shared_pin_is_ref_o == setup[SHARED_PIN_ROLE_POS])
    else $error("shared pin role does not follow select bit");
  diff_ground_a: assert property (state == ST_IDLE && pending && !setup_wr |=>
    conv_neg_ground_o |-> conv_diff_o && shared_pin_is_ref_o) else $error("ground without reference role");
  scan_limit_a: assert property ((scan && pin_is_ref && !setup[DIFFERENTIAL_POS]) ##0 s_issue_ready
    |=> conv_last_chan_o <= SCAN_LIMIT)
    else $error("scan reached the shared pin");
  ref_drive_a: assert property (!shared_pin_ref_oe_n_o |-> ref_out_sel && ref_power && !shutdown)
    else $error("shared pin driven without output selection");
  ref_hold_a: assert property (ref_power && !setup_wr |=> ref_power)
    else $error("reference dropped without reconfiguration");
  wake_wait_a: assert property (conv_start_o && internal_sel |-> $past(ref_ready))
    else $error("conversion issued before reference wake-up");
  shutdown_hiz_a: assert property (shutdown |-> shared_pin_ref_oe_n_o && !shared_pin_ref_out_o)
    else $error("reference output active in shutdown");
  result_code_a: assert property (s_sample_taken |=> result == ($past(setup[BIPOLAR_POS])
    ? {~$past(sample_raw_i[RESULT_BITS-1]), $past(sample_raw_i[RESULT_BITS-2:0])} : $past(sample_raw_i)))
    else $error("result coding mismatch");
  no_wake_a: assert property (s_issue_ready ##0 !internal_sel |=> conv_start_o ##1 state == ST_CONV)
    else $error("delay added for external or supply reference");
  decode_off_a: assert property (!internal_sel && !setup_wr |=> !ref_power)
    else $error("internal reference on with non-internal code");
endmodule : adc_ref_ctrl

// ==== bench/adc_core_model.sv ====
// Purpose: Behavioural converter core that answers each conversion start with one sample
// Assumes: Same clock as the controller, one start pulse per conversion
// Notes: Raw data means something only with the valid pulse; it toggles otherwise
`timescale 1ns/10ps
module adc_core_model (
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  input wire logic conv_start_i,
  output logic sample_valid_o,
  output logic [adc_ref_pkg::RESULT_BITS-1:0] sample_raw_o
);
  int unsigned wait_cnt;
  always @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wait_cnt <= 0;
      sample_valid_o <= 1'b0;
      sample_raw_o <= 12'hA5A;
    end else begin
      sample_valid_o <= 1'b0;
      // Toggling keeps a late capture from matching by luck
      sample_raw_o <= ~sample_raw_o;
      if (conv_start_i) begin
        wait_cnt <= 1 + $urandom_range(6);
      end else if (wait_cnt == 1) begin
        wait_cnt <= 0;
        sample_valid_o <= 1'b1;
        sample_raw_o <= 12'($urandom);
      end else if (wait_cnt != 0) begin
        wait_cnt <= wait_cnt - 1;
      end
    end
  end
endmodule : adc_core_model

// ==== bench/adc_reference_select_and_coding_tb.sv ====
// Purpose: Self-checking bench for reference select, pin role and result coding
// Assumes: Wake time shortened to 8 cycles, twelve-input variant
// Notes: Samples are random from the core model; expectations come from bench functions
`timescale 1ns/10ps
module adc_reference_select_and_coding_tb;
  import adc_ref_pkg::*;
  logic sys_clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, svalid, cstart, cdiff, cng, rpow, rint, pref, pout, poe_n;
  logic [3:0] awaddr = 4'h0, araddr = 4'h0, wstrb = 4'hF, lchan;
  logic [31:0] wdata = 32'h0, rdata;
  logic [1:0] bresp, rresp;
  logic [11:0] sraw, last_raw = 12'h000;
  int err_total = 0, checks = 0, cyc = 0, nstart = 0, start_cyc = 0;

  adc_ref_ctrl #(.WAKE_CYCLES(8), .NUM_CH(12)) adc_ref_ctrl_inst (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i),
    .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready), .s_axi_awaddr_i(awaddr), .s_axi_wvalid_i(wvalid),
    .s_axi_wready_o(wready), .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb), .s_axi_bvalid_o(bvalid),
    .s_axi_bready_i(bready), .s_axi_bresp_o(bresp), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
    .s_axi_araddr_i(araddr), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .s_axi_rdata_o(rdata),
    .s_axi_rresp_o(rresp), .sample_valid_i(svalid), .sample_raw_i(sraw), .conv_start_o(cstart),
    .conv_last_chan_o(lchan), .conv_diff_o(cdiff), .conv_neg_ground_o(cng), .ref_power_o(rpow),
    .ref_internal_o(rint), .shared_pin_is_ref_o(pref), .shared_pin_ref_out_o(pout),
    .shared_pin_ref_oe_n_o(poe_n));
  adc_core_model adc_core_model_inst (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .conv_start_i(cstart),
    .sample_valid_o(svalid), .sample_raw_o(sraw));

  always #4 sys_clk_i = ~sys_clk_i;

  task complete_run();
    if (err_total == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : complete_run

  // Ceiling well above the several hundred cycles the sequence needs
  always @(posedge sys_clk_i) begin
    cyc <= cyc + 1;
    if (cstart === 1'b1) begin
      nstart <= nstart + 1;
      start_cyc <= cyc;
    end
    if (svalid === 1'b1) begin
      last_raw <= sraw;
    end
    if (cyc == 20000) begin
      err_total = err_total + 1;
      complete_run();
    end
  end

  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks = checks + 1;
    if (got !== exp) begin
      err_total = err_total + 1;
      $display("ERROR %0t: saw %h, expected %h", $time, got, exp);
    end
  endtask : chk

  function automatic logic [11:0] coded(input logic [11:0] raw, input logic bip);
    return bip ? {~raw[11], raw[10:0]} : raw;
  endfunction : coded

  function automatic logic [3:0] exp_last(input logic [3:0] ch, input logic scan, input logic pin, input logic dif);
    return (scan && pin && !dif && ch > 4'hA) ? 4'hA : ch;
  endfunction : exp_last

  task axi_wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw_ok;
    logic w_ok;
    @(posedge sys_clk_i);
    awvalid <= 1'b1;
    awaddr <= a;
    wvalid <= 1'b1;
    wdata <= d;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    while (!(aw_ok && w_ok)) begin
      @(posedge sys_clk_i);
      if (awvalid && awready === 1'b1) begin
        aw_ok = 1'b1;
        awvalid <= 1'b0;
      end
      if (wvalid && wready === 1'b1) begin
        w_ok = 1'b1;
        wvalid <= 1'b0;
      end
    end
    bready <= 1'b1;
    do @(posedge sys_clk_i); while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
  endtask : axi_wr

  task axi_rd(input logic [3:0] a, output logic [31:0] v);
    @(posedge sys_clk_i);
    arvalid <= 1'b1;
    araddr <= a;
    do @(posedge sys_clk_i); while (arready !== 1'b1);
    arvalid <= 1'b0;
    rready <= 1'b1;
    do @(posedge sys_clk_i); while (rvalid !== 1'b1);
    v = rdata;
    rready <= 1'b0;
  endtask : axi_rd

  // Writes setup, requests one conversion, returns cycles from write answer to start
  task conv(input logic [5:0] s, input logic [4:0] cs, output int d);
    int n0;
    logic [1:0] r;
    logic [31:0] v;
    axi_wr(SETUP_OFFS, {26'h0, s}, r);
    n0 = nstart;
    axi_wr(CONV_OFFS, {23'h0, 1'b1, 3'h0, cs}, r);
    d = cyc;
    while (nstart == n0) @(posedge sys_clk_i);
    d = start_cyc - d;
    chk(lchan, exp_last(cs[3:0], cs[4], s[1], s[4]));
    chk(cdiff, s[4]);
    chk(cng, s[4] && s[1] && cs[3:1] == 3'h5);
    v = 32'h1;
    while (v[ST_BUSY_POS] !== 1'b0) axi_rd(STATUS_OFFS, v);
    chk(v[ST_DONE_POS], 1'b1);
    chk(v[ST_PIN_REF_POS], s[1]);
    axi_rd(RESULT_OFFS, v);
    chk(v, {20'h0, coded(last_raw, s[BIPOLAR_POS])});
  endtask : conv

  initial begin
    logic [1:0] r;
    logic [31:0] v;
    logic [5:0] s;
    logic [4:0] cs;
    int d;
    void'($urandom(16339));
    repeat (5) @(posedge sys_clk_i);
    nrst_i <= 1'b1;
    chk(poe_n, 1'b1);
    chk(rpow, 1'b0);
    axi_rd(SETUP_OFFS, v);
    chk(v, 32'h0);
    axi_rd(CONV_OFFS, v);
    chk(v, 32'h0);
    axi_wr(STATUS_OFFS, 32'h3F, r);
    chk(r, RESP_SLVERR);
    for (int c = 0; c < 8; c++) begin
      axi_wr(SETUP_OFFS, c, r);
      chk(r, RESP_OKAY);
      repeat (3) @(posedge sys_clk_i);
      chk(rint, c[2]);
      chk(pref, c[1]);
      chk(rpow, c[2] & c[0]);
      chk(poe_n, !(c[2:0] == 3'h7));
      chk(pout, c[2:0] == 3'h7);
    end
    axi_wr(SETUP_OFFS, 32'h27, r);
    repeat (3) @(posedge sys_clk_i);
    chk(poe_n, 1'b1);
    chk(pout, 1'b0);
    chk(rpow, 1'b1);
    // A start request in shutdown must wait until shutdown is lifted
    d = nstart;
    axi_wr(CONV_OFFS, 32'h100, r);
    repeat (20) @(posedge sys_clk_i);
    chk(nstart, d);
    axi_wr(SETUP_OFFS, 32'h07, r);
    v = 32'h1;
    while (v[ST_BUSY_POS] !== 1'b0) axi_rd(STATUS_OFFS, v);
    chk(nstart, d + 1);
    for (int i = 0; i < 12; i++) begin
      s = {2'b00, 4'($urandom_range(15) & 4'hB)};
      cs = {1'($urandom), 4'($urandom_range(11))};
      if (i == 0) begin
        s = 6'h02;
        cs = 5'h1B;
      end else if (i == 1) begin
        s = 6'h12;
        cs = 5'h0A;
      end
      conv(s, cs, d);
      chk(d <= 3, 1'b1);
    end
    conv(6'h04, 5'h00, d);
    chk(d >= 8, 1'b1);
    chk(rpow, 1'b1);
    conv(6'h0C, 5'h03, d);
    chk(rpow, 1'b1);
    complete_run();
  end
endmodule : adc_reference_select_and_coding_tb
